// *** inc/dpram_port_regs.svh ***
`ifndef DPRAM_PORT_REGS_SVH
`define DPRAM_PORT_REGS_SVH

// ****************************************************************
// Widths and mailbox locations
// ****************************************************************
`define DPR_ADDR_W          18
`define DPR_DATA_W          18
`define MAILBOX_LEFT_ADDR   18'h3FFFE
`define MAILBOX_RIGHT_ADDR  18'h3FFFF

// ****************************************************************
// Timing, in ns and in cycles of ref_clk
// ****************************************************************
`define CLK_PERIOD_NS       8
`define ARB_SETTLE_NS       15
`define READ_ACCESS_NS      20
`define WRITE_PULSE_NS      12
`define ARB_SETTLE_CYC      ((`ARB_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_CYC     ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC     ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** inc/dpram_port_pkg.sv ***
package dpram_port_pkg;
	`include "dpram_port_regs.svh"

	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_SEM_READ,
		OP_SEM_WRITE
	} op_type;

	typedef struct packed {
		op_type                   op;
		logic [`DPR_ADDR_W-1:0]   addr;
		logic [`DPR_DATA_W-1:0]   data;
	} cmd_type;

	typedef struct packed {
		logic                     memSel_n;
		logic                     flagSpaceSelect_n;
		logic                     rdWr_n;
		logic                     outEn_n;
		logic [`DPR_ADDR_W-1:0]   addr;
	} port_pins_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARB,
		ST_ACT,
		ST_DONE
	} state_type;
endpackage

// *** hdl/dpram_port_ctrl.sv ***
`timescale 1ns/1ps
`include "dpram_port_regs.svh"
module dpram_port_ctrl
	import dpram_port_pkg::*;
#(
	parameter bit IS_LEFT      = 1'b1,
	parameter bit USE_ARB      = 1'b1,
	parameter bit BLOCK_WRITES = 1'b0,
	parameter int NUM_DEV      = 1
) (
	input  wire logic                   ref_clk,
	input  wire logic                   arst_n,
	input  wire logic                   cmdValid,
	input  wire cmd_type                cmd,
	output logic                        cmdReady,
	output logic                        rspValid,
	output logic [`DPR_DATA_W-1:0]      rspData,
	output logic                        mailboxPending,
	output port_pins_type               pins,
	input  wire logic [`DPR_DATA_W-1:0] dataIn,
	output logic [`DPR_DATA_W-1:0]      dataOut,
	output logic                        dataOe,
	input  wire logic [NUM_DEV-1:0]     conflictFlagIn_n,
	output logic                        conflictFlagOut_n,
	output logic                        conflictFlagOe,
	output logic                        masterSel,
	input  wire logic                   mailboxFlagIn_n
);

	// ****************************************************************
	// Constants
	// ****************************************************************
	localparam logic [`DPR_ADDR_W-1:0] OWN_MAILBOX =
		IS_LEFT ? `MAILBOX_LEFT_ADDR : `MAILBOX_RIGHT_ADDR;
	localparam logic [3:0] ARB_CYC = 4'(`ARB_SETTLE_CYC);
	localparam logic [3:0] RD_CYC  = 4'(`READ_ACCESS_CYC);
	localparam logic [3:0] WR_CYC  = 4'(`WRITE_PULSE_CYC);
	localparam port_pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, '0};

	// ****************************************************************
	// State
	// ****************************************************************
	state_type                  state_r, state_nxt;
	cmd_type                    cur_r, cur_nxt;
	port_pins_type              pins_r, pins_nxt;
	logic [3:0]                 cnt_r, cnt_nxt;
	logic                       initPending_r, initPending_nxt;
	logic                       cmdReady_r, cmdReady_nxt;
	logic                       rspValid_r, rspValid_nxt;
	logic [`DPR_DATA_W-1:0]     rspData_r, rspData_nxt;
	logic [`DPR_DATA_W-1:0]     dataOut_r, dataOut_nxt;
	logic                       dataOe_r, dataOe_nxt;
	logic                       mailboxPending_r;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire busyAll  = USE_ARB && !(&conflictFlagIn_n);
	wire take     = initPending_r || (cmdValid && cmdReady_r);
	wire cmd_type nextCmd = initPending_r ? cmd_type'({OP_READ, OWN_MAILBOX,
		{`DPR_DATA_W{1'b0}}}) : cmd;
	wire isSem    = (nextCmd.op == OP_SEM_READ) || (nextCmd.op == OP_SEM_WRITE);
	wire isWrite  = (nextCmd.op == OP_WRITE) || (nextCmd.op == OP_SEM_WRITE);
	wire curWrite = (cur_r.op == OP_WRITE) || (cur_r.op == OP_SEM_WRITE);
	wire [`DPR_DATA_W-1:0] wrData = (nextCmd.op == OP_SEM_WRITE) ?
		{{(`DPR_DATA_W-1){1'b0}}, nextCmd.data[0]} : nextCmd.data;
	wire lastCnt  = (cnt_r == 4'h1);

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	always_comb begin
		state_nxt       = state_r;
		cur_nxt         = cur_r;
		pins_nxt        = pins_r;
		cnt_nxt         = cnt_r;
		initPending_nxt = initPending_r;
		cmdReady_nxt    = cmdReady_r;
		rspValid_nxt    = 1'b0;
		rspData_nxt     = rspData_r;
		dataOut_nxt     = dataOut_r;
		dataOe_nxt      = dataOe_r;
		case (state_r)
			ST_IDLE: begin
				cmdReady_nxt = !initPending_r;
				if (take) begin
					cur_nxt                    = nextCmd;
					initPending_nxt            = 1'b0;
					cmdReady_nxt               = 1'b0;
					pins_nxt.addr              = nextCmd.addr;
					pins_nxt.memSel_n          = isSem;
					pins_nxt.flagSpaceSelect_n = !isSem;
					dataOut_nxt                = wrData;
					dataOe_nxt                 = isWrite;
					cnt_nxt                    = ARB_CYC;
					state_nxt                  = ST_ARB;
				end
			end
			ST_ARB: begin
				// Selects settle before any strobe so the arbiter decides first
				if (!lastCnt) begin
					cnt_nxt = cnt_r - 4'h1;
				end else if (!busyAll) begin
					pins_nxt.rdWr_n  = !curWrite;
					pins_nxt.outEn_n = curWrite;
					cnt_nxt          = curWrite ? WR_CYC : RD_CYC;
					state_nxt        = ST_ACT;
				end
			end
			ST_ACT: begin
				if (!lastCnt) begin
					cnt_nxt = cnt_r - 4'h1;
				end else begin
					pins_nxt.rdWr_n  = 1'b1;
					pins_nxt.outEn_n = 1'b1;
					rspData_nxt      = curWrite ? rspData_r : dataIn;
					rspValid_nxt     = 1'b1;
					state_nxt        = ST_DONE;
				end
			end
			ST_DONE: begin
				// Dropping both selects also re-arms the semaphore read latch
				pins_nxt     = PINS_IDLE;
				dataOe_nxt   = 1'b0;
				cmdReady_nxt = 1'b1;
				state_nxt    = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
				pins_nxt  = PINS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r       <= ST_IDLE;
			cur_r         <= '0;
			pins_r        <= PINS_IDLE;
			cnt_r         <= 4'h0;
			initPending_r <= 1'b1;
			cmdReady_r    <= 1'b0;
			rspValid_r    <= 1'b0;
			rspData_r     <= '0;
			dataOut_r     <= '0;
			dataOe_r      <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			cur_r         <= cur_nxt;
			pins_r        <= pins_nxt;
			cnt_r         <= cnt_nxt;
			initPending_r <= initPending_nxt;
			cmdReady_r    <= cmdReady_nxt;
			rspValid_r    <= rspValid_nxt;
			rspData_r     <= rspData_nxt;
			dataOut_r     <= dataOut_nxt;
			dataOe_r      <= dataOe_nxt;
		end
	end

	// ****************************************************************
	// Strap, conflict tie and mailbox status
	// ****************************************************************
	// The strap is a fixed build choice; changing mode on the fly is unsupported
	logic conflictOut_r;
	logic conflictOe_r;
	logic masterSel_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			conflictOut_r    <= 1'b1;
			conflictOe_r     <= 1'b0;
			masterSel_r      <= 1'b1;
			mailboxPending_r <= 1'b0;
		end else begin
			conflictOut_r    <= !BLOCK_WRITES;
			conflictOe_r     <= !USE_ARB;
			masterSel_r      <= USE_ARB;
			mailboxPending_r <= !mailboxFlagIn_n;
		end
	end

	assign cmdReady          = cmdReady_r;
	assign rspValid          = rspValid_r;
	assign rspData           = rspData_r;
	assign pins              = pins_r;
	assign dataOut           = dataOut_r;
	assign dataOe            = dataOe_r;
	assign conflictFlagOut_n = conflictOut_r;
	assign conflictFlagOe    = conflictOe_r;
	assign masterSel         = masterSel_r;
	assign mailboxPending    = mailboxPending_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_strobeFall;
		$fell(pins_r.rdWr_n) || $fell(pins_r.outEn_n);
	endsequence

	sequence s_initRead;
		pins_r.memSel_n == 1'b0 && pins_r.addr == OWN_MAILBOX && !dataOe_r;
	endsequence

	property p_semSelect;
		@(posedge ref_clk) disable iff (!arst_n)
		!pins_r.flagSpaceSelect_n |-> pins_r.memSel_n;
	endproperty
	a_semSelect: assert property (p_semSelect) else $error("semaphore access with memory selected");

	property p_stall;
		@(posedge ref_clk) disable iff (!arst_n)
		s_strobeFall |-> !$past(busyAll);
	endproperty
	a_stall: assert property (p_stall) else $error("strobe started while conflict low");

	property p_writeLen;
		@(posedge ref_clk) disable iff (!arst_n)
		$fell(pins_r.rdWr_n) |-> !pins_r.rdWr_n [*2] ##1 pins_r.rdWr_n;
	endproperty
	a_writeLen: assert property (p_writeLen) else $error("write pulse length wrong");

	property p_settle;
		@(posedge ref_clk) disable iff (!arst_n)
		s_strobeFall |-> $past(!pins_r.memSel_n || !pins_r.flagSpaceSelect_n, 2);
	endproperty
	a_settle: assert property (p_settle) else $error("strobe before selects settled");

	property p_strap;
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(arst_n) ##1 1'b1 |-> conflictFlagOe == !USE_ARB && masterSel == USE_ARB
			&& conflictFlagOut_n == !BLOCK_WRITES;
	endproperty
	a_strap: assert property (p_strap) else $error("strap or conflict tie wrong");

	property p_cascade;
		@(posedge ref_clk) disable iff (!arst_n)
		(USE_ARB && state_r == ST_ARB && lastCnt && conflictFlagIn_n != {NUM_DEV{1'b1}})
			|=> pins_r.rdWr_n && pins_r.outEn_n && state_r == ST_ARB;
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascaded conflict not combined");

	property p_initRead;
		@(posedge ref_clk)
		$rose(arst_n) |-> ##[1:3] s_initRead;
	endproperty
	a_initRead: assert property (p_initRead) else $error("no mailbox read after reset");

	property p_semData;
		@(posedge ref_clk) disable iff (!arst_n)
		(dataOe_r && !pins_r.flagSpaceSelect_n) |-> dataOut_r[`DPR_DATA_W-1:1] == '0;
	endproperty
	a_semData: assert property (p_semData) else $error("semaphore write uses upper bits");

	property p_noFight;
		@(posedge ref_clk) disable iff (!arst_n)
		!pins_r.outEn_n |-> !dataOe_r;
	endproperty
	a_noFight: assert property (p_noFight) else $error("data driven while reading");

endmodule

// *** testbench/dpram_dev_model.sv ***
`timescale 1ns/1ps
`include "dpram_port_regs.svh"
// ****
// Far-side memory device, right port driven by the bench
// ****
module dpram_dev_model
	import dpram_port_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          arst_n,
	input  wire port_pins_type pins,
	input  wire logic [17:0]   hostData,
	output logic [17:0]        dataIn,
	output logic               conflictL_n,
	output logic               mbLeft_n,
	output logic               mbRight_n,
	output logic               badAccess,
	input  wire logic          rSel_n,
	input  wire logic          rFlag_n,
	input  wire logic          rWr_n,
	input  wire logic [17:0]   rAddr,
	input  wire logic [17:0]   rData,
	input  wire logic          hostOe,
	input  wire logic          masterSel,
	input  wire logic          slaveTie_n
);
	logic [17:0] mem [0:262143];
	logic [1:0]  owner [8];
	logic [7:0]  req [1:2];
	logic [17:0] lastVal;
	wire         drive = !pins.outEn_n && (!pins.memSel_n || !pins.flagSpaceSelect_n);
	wire [17:0]  semVal = {18{owner[pins.addr[2:0]] != 2'h1}};
	// Released bus shows the inverse of its last value, never a held copy
	assign dataIn = drive ? (pins.memSel_n ? semVal : mem[pins.addr]) : ~lastVal;
	// Right side always settles first here, so only the left flag can fall
	assign conflictL_n = !masterSel
		|| !(!rSel_n && !pins.memSel_n && rAddr == pins.addr);
	// A slave takes its write inhibit from the strap tie instead
	wire         leftWrOk = masterSel ? conflictL_n : slaveTie_n;
	task automatic semWr(input logic [1:0] s, input logic [2:0] i, input logic d);
		if (!d) begin
			if (owner[i] == 2'h0) owner[i] = s;
			else if (owner[i] != s) req[s][i] = 1'b1;
		end else if (owner[i] == s) begin
			owner[i] = req[3 - s][i] ? 2'(3 - s) : 2'h0;
			req[3 - s][i] = 1'b0;
		end else req[s][i] = 1'b0;
	endtask
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			foreach (owner[k]) owner[k] = 2'h0;
			req[1] = 8'h00;
			req[2] = 8'h00;
			mbLeft_n = 1'b1;
			mbRight_n = 1'b1;
			badAccess = 1'b0;
			lastVal = 18'h00000;
		end else begin
			if (drive) lastVal = dataIn;
			if (!pins.memSel_n && !pins.outEn_n && pins.addr == `MAILBOX_LEFT_ADDR) mbLeft_n = 1'b1;
			if (!pins.memSel_n && !pins.flagSpaceSelect_n) badAccess = 1'b1;
			// Both sides driving the data pins at once is a bus fight
			if (hostOe && drive) badAccess = 1'b1;
		end
	end
	always @(posedge pins.rdWr_n) begin
		if (arst_n && !pins.memSel_n && leftWrOk) begin
			mem[pins.addr] = hostOe ? hostData : ~hostData;
			if (pins.addr == `MAILBOX_RIGHT_ADDR) mbRight_n = 1'b0;
		end
		if (arst_n && pins.memSel_n && !pins.flagSpaceSelect_n) semWr(2'h1, pins.addr[2:0], hostData[0]);
	end
	always @(posedge rWr_n) begin
		if (!rFlag_n) semWr(2'h2, rAddr[2:0], rData[0]);
		else if (!rSel_n) begin
			mem[rAddr] = rData;
			if (rAddr == `MAILBOX_LEFT_ADDR) mbLeft_n = 1'b0;
		end
	end
endmodule

// *** testbench/dpram_port_ctrl_bench.sv ***
`timescale 1ns/1ps
module dpram_port_ctrl_bench
	import dpram_port_pkg::*;
();
	logic          ref_clk = 1'b0;
	logic          arst_n = 1'b0;
	logic          cmdValid = 1'b0;
	cmd_type       cmd = '0;
	logic          rSel_n = 1'b1;
	logic          rFlag_n = 1'b1;
	logic          rWr_n = 1'b1;
	logic [17:0]   rAddr = 18'h00000;
	logic [17:0]   rData = 18'h00000;
	logic [17:0]   rdVal;
	int            miscompares = 0;
	int            checksDone = 0;
	wire           cmdReady, rspValid, mailboxPending, dataOe, flagOut_n, flagOe, masterSel;
	wire [17:0]    rspData, dataIn, dataOut;
	wire           conflictL_n, mbLeft_n, mbRight_n, badAccess;
	port_pins_type pins;
	dpram_port_ctrl dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
		.mailboxPending(mailboxPending), .pins(pins), .dataIn(dataIn), .dataOut(dataOut),
		.dataOe(dataOe), .conflictFlagIn_n(conflictL_n), .conflictFlagOut_n(flagOut_n),
		.conflictFlagOe(flagOe), .masterSel(masterSel), .mailboxFlagIn_n(mbLeft_n));
	dpram_dev_model dev (
		.ref_clk(ref_clk), .arst_n(arst_n), .pins(pins), .hostData(dataOut),
		.dataIn(dataIn), .conflictL_n(conflictL_n), .mbLeft_n(mbLeft_n),
		.mbRight_n(mbRight_n), .badAccess(badAccess), .rSel_n(rSel_n), .rFlag_n(rFlag_n),
		.rWr_n(rWr_n), .rAddr(rAddr), .rData(rData), .hostOe(dataOe),
		.masterSel(masterSel), .slaveTie_n(flagOut_n));
	initial forever #4 ref_clk = ~ref_clk;
	task completeRun;
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
		checksDone++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic waitHigh(input int n, input logic sig);
		if (n >= 100) begin
			check("handshake", 18'h00001, {17'h0, sig});
			completeRun;
		end
	endtask
	task automatic doCmd(input op_type op, input logic [17:0] a, input logic [17:0] d);
		int n;
		n = 0;
		while (cmdReady !== 1'b1 && n < 100) begin @(negedge ref_clk); n++; end
		waitHigh(n, cmdReady);
		cmd = '{op, a, d};
		cmdValid = 1'b1;
		@(negedge ref_clk);
		cmdValid = 1'b0;
		n = 0;
		while (rspValid !== 1'b1 && n < 100) begin @(negedge ref_clk); n++; end
		waitHigh(n, rspValid);
		rdVal = rspData;
	endtask
	task automatic rightWr(input logic flag, input logic [17:0] a, input logic [17:0] d);
		rAddr = a;
		rData = d;
		rFlag_n = !flag;
		rSel_n = flag;
		@(negedge ref_clk);
		rWr_n = 1'b0;
		@(negedge ref_clk);
		rWr_n = 1'b1;
		@(negedge ref_clk);
		rSel_n = 1'b1;
		rFlag_n = 1'b1;
	endtask
	task automatic test_memory;
		doCmd(OP_WRITE, 18'h12345, 18'h2AAAA);
		check("masterSel", 18'h1, {17'h0, masterSel});
		check("conflictFlagOe", 18'h0, {17'h0, flagOe});
		check("conflict tie", 18'h1, {17'h0, flagOut_n});
		doCmd(OP_READ, 18'h12345, 18'h0);
		check("word", 18'h2AAAA, rdVal);
		doCmd(OP_WRITE, 18'h3FFFF, 18'h15555);
		check("peer flag", 18'h0, {17'h0, mbRight_n});
		doCmd(OP_READ, 18'h3FFFF, 18'h0);
		check("peer box", 18'h15555, rdVal);
		$display("test memory done");
	endtask
	task automatic test_mailbox;
		rightWr(1'b0, 18'h3FFFE, 18'h3C3C3);
		repeat (3) @(negedge ref_clk);
		check("pending set", 18'h1, {17'h0, mailboxPending});
		doCmd(OP_READ, 18'h3FFFE, 18'h0);
		check("own box", 18'h3C3C3, rdVal);
		repeat (3) @(negedge ref_clk);
		check("pending clear", 18'h0, {17'h0, mailboxPending});
		$display("test mailbox done");
	endtask
	task automatic test_semaphore;
		doCmd(OP_SEM_WRITE, 18'h3, 18'h0);
		doCmd(OP_SEM_READ, 18'h3, 18'h0);
		check("take", 18'h00000, rdVal);
		rightWr(1'b1, 18'h3, 18'h0);
		doCmd(OP_SEM_READ, 18'h3, 18'h0);
		check("still held", 18'h00000, rdVal);
		doCmd(OP_SEM_WRITE, 18'h3, 18'h1);
		doCmd(OP_SEM_READ, 18'h3, 18'h0);
		check("passed", 18'h3FFFF, rdVal);
		doCmd(OP_SEM_WRITE, 18'h3, 18'h0);
		rightWr(1'b1, 18'h3, 18'h1);
		doCmd(OP_SEM_READ, 18'h3, 18'h0);
		check("returned", 18'h00000, rdVal);
		doCmd(OP_SEM_WRITE, 18'h3, 18'h1);
		doCmd(OP_SEM_READ, 18'h3, 18'h0);
		check("freed", 18'h3FFFF, rdVal);
		doCmd(OP_SEM_READ, 18'h5, 18'h0);
		check("other flag", 18'h3FFFF, rdVal);
		check("select pair", 18'h0, {17'h0, badAccess});
		$display("test semaphore done");
	endtask
	task automatic test_conflict;
		rAddr = 18'h00400;
		rSel_n = 1'b0;
		fork
			doCmd(OP_WRITE, 18'h00400, 18'h0BEEF);
			begin
				repeat (10) @(negedge ref_clk);
				check("stalled strobe", 18'h1, {17'h0, pins.rdWr_n});
				rSel_n = 1'b1;
			end
		join
		doCmd(OP_READ, 18'h00400, 18'h0);
		check("after stall", 18'h0BEEF, rdVal);
		check("no fight", 18'h0, {17'h0, badAccess});
		$display("test conflict done");
	endtask
	initial begin
		repeat (6) @(negedge ref_clk);
		arst_n = 1'b1;
		test_memory();
		test_mailbox();
		test_semaphore();
		test_conflict();
		completeRun();
	end
endmodule
